// >>> rtl/seq_prog_defines.svh
/*
   Constants for the sequential byte program block: command codes, status bit
   positions, transfer lengths and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef SEQ_PROG_DEFINES_SVH
`define SEQ_PROG_DEFINES_SVH

// Timing of one self-timed byte program.
`define SEQ_CLK_PERIOD_NS      5
`define SEQ_BYTE_PROG_TIME_NS  8000
`define SEQ_BP_CYCLES ((`SEQ_BYTE_PROG_TIME_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS)

// Status register one bit positions.
`define SR1_BUSY_BIT  0
`define SR1_WEL_BIT   1
`define SR1_SEQ_BIT   2

// Frame lengths in whole bytes.
`define SEQ_INIT_BYTES  4'h5
`define SEQ_NEXT_BYTES  4'h2

// Array geometry.
`define SEQ_LAST_ADDR   24'h0FFFFF
`define SEQ_BLOCK_LSB   16

// Command codes.
`define CMD_SEQ_A    8'hAD
`define CMD_SEQ_B    8'hAF
`define CMD_WREN     8'h06
`define CMD_WRDI     8'h04
`define CMD_ACT_INT  8'h25
`define CMD_TERM     8'hF0
`define CMD_RST_EN   8'h66
`define CMD_RST      8'h99
`define CMD_RDSR1    8'h05
`define CMD_RDSR2    8'h35
`define CMD_RDSR3    8'h15
`define CMD_RDSR_IND 8'h65
`define CMD_ID_A     8'h9F
`define CMD_ID_B     8'h90
`define CMD_ID_C     8'h94

`endif

// >>> rtl/seq_prog_pkg.sv
/*
   Types for the sequential byte program block. Assumes nothing beyond the
   constants header for the figures.
*/
package seq_prog_pkg;
   typedef enum logic {ST_IDLE, ST_PROG} prog_state_e;
endpackage

// >>> rtl/sequential_byte_program_mode.sv
/*
   Sequential byte program mode of a serial flash: frame capture on the serial
   clock, command gating, self-timed byte program, exits and error flags.
   Assumes an SPI mode 0/3 host on csN/sck/mosi, and that the array returns a
   fail level on progFail while a program is running.
*/
// What this block does
// - Busy held high during self-timed byte program.
// - While busy, ignore all but permitted commands.
// - In mode, allow only listed control commands.
// - In mode, allow status register reads.
// - In mode, allow identification reads.
// - In mode, reject reads, erases, programs.
// - In mode, reject status writes, locks, OTP.
// - In mode, reject suspend, power-down, SFDP, misc.
// - Several data bytes: program only last one.
// - Partial byte at release aborts, clears latch.
// - Protected start address: no program, clear latch.
// - Stop mode before protected block, clear latch.
// - No wrap: stop after last location.
// - Entering erase-suspended block ends the mode.
// - Latch cleared in mode ends the mode.
// - Program failure sets both error flags.
// - Busy is bit 0 of status register one.
// - Initial frame: command, address MSB first, data.
// - Later frames: command and data at counter.
`timescale 1ns/100ps
`include "seq_prog_defines.svh"

module sequential_byte_program_mode
#(
   parameter int          NUM_BLOCKS = 16,
   parameter logic [23:0] LAST_ADDR  = `SEQ_LAST_ADDR
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  sck,
   input  wire logic                  csN,
   input  wire logic                  mosi,
   input  wire logic [NUM_BLOCKS-1:0] protectMap,
   input  wire logic                  eraseSuspended,
   input  wire logic [7:0]            suspendBlock,
   input  wire logic                  progFail,
   output logic                       busyFlag,
   output logic                       writeLatch,
   output logic                       seqProgramFlag,
   output logic [7:0]                 statusRegOne,
   output logic                       eraseErrorFlag,
   output logic                       programErrorFlag,
   output logic                       progStart,
   output logic [23:0]                progAddr,
   output logic [7:0]                 progData,
   output logic                       cmdAccept,
   output logic                       cmdReject,
   output logic [7:0]                 cmdCode,
   output logic                       deviceReset
);

   localparam int          BP_CYCLES = `SEQ_BP_CYCLES;
   localparam logic [12:0] BP_LOAD   = 13'(BP_CYCLES);

   // Status register reads, legal both while busy and in the mode.
   function automatic logic isStatusRead(input logic [7:0] c);
      return c == `CMD_RDSR1 || c == `CMD_RDSR2 || c == `CMD_RDSR3 || c == `CMD_RDSR_IND;
   endfunction

   // Commands the device still takes while a self-timed operation runs.
   function automatic logic busyAllowed(input logic [7:0] c);
      return isStatusRead(c) || c == `CMD_ACT_INT || c == `CMD_TERM ||
             c == `CMD_RST_EN || c == `CMD_RST;
   endfunction

   // Commands the device takes while idle in the mode; everything else is refused.
   function automatic logic seqAllowed(input logic [7:0] c);
      return busyAllowed(c) || c == `CMD_SEQ_A || c == `CMD_SEQ_B ||
             c == `CMD_WREN || c == `CMD_WRDI ||
             c == `CMD_ID_A || c == `CMD_ID_B || c == `CMD_ID_C;
   endfunction

   // A 64 kB block is protected when its map bit is set or it lies off the map.
   function automatic logic blockProt(input logic [NUM_BLOCKS-1:0] m,
                                      input logic [23:0]           a);
      logic [7:0] idx;
      idx = a[23:`SEQ_BLOCK_LSB];
      return (32'(idx) >= NUM_BLOCKS) ? 1'b1 : m[idx[$clog2(NUM_BLOCKS)-1:0]];
   endfunction

   // Link domain. The first flop is cleared by the frame's own chip select, so
   // no sck edge is needed after a frame ends; captured fields stay frozen
   // between frames and are read by the system domain only then.
   logic        inFrame;
   logic [2:0]  bitLow;
   logic [3:0]  byteCnt;
   logic [6:0]  shiftReg;
   logic [7:0]  capCmd;
   logic [23:0] capAddr;
   logic [7:0]  capData;

   wire         byteDone = inFrame && bitLow == 3'h7;
   wire [7:0]   newByte  = {shiftReg, mosi};
   wire [3:0]   byteNo   = (byteCnt == 4'hF) ? 4'hF : byteCnt + 4'h1;

   always_ff @(posedge sck or posedge csN)
   begin
      if (csN)
         inFrame <= 1'b0;
      else
         inFrame <= 1'b1;
   end

   // Bit and byte counting; the byte count saturates, the bit phase wraps.
   always_ff @(posedge sck)
   begin
      shiftReg <= newByte[6:0];
      bitLow   <= inFrame ? bitLow + 3'h1 : 3'h1;
      byteCnt  <= !inFrame ? 4'h0 : (byteDone ? byteNo : byteCnt);
   end

   // Field capture, MSB first; each new data byte overwrites the previous one.
   always_ff @(posedge sck)
   begin
      if (byteDone && byteNo == 4'h1)
         capCmd <= newByte;
      if (byteDone && byteNo >= 4'h2 && byteNo <= 4'h4)
         capAddr <= {capAddr[15:0], newByte};
      if (byteDone && byteNo >= 4'h2)
         capData <= newByte;
   end

   // System domain: chip select through two flops, then rising edge detect.
   logic csMeta;
   logic csSync;
   logic csLast;

   always_ff @(posedge clk_sys)
   begin
      csMeta <= csN;
      csSync <= csMeta;
      csLast <= nrst ? csSync : 1'b1;
   end

   wire frameEnd = csSync && !csLast;

   // Frame decode. A frame counts only if it ended on a byte boundary.
   wire wholeBytes = (bitLow == 3'h0) && byteCnt != 4'h0;
   wire isSeqCmd   = capCmd == `CMD_SEQ_A || capCmd == `CMD_SEQ_B;
   wire initOk     = wholeBytes && byteCnt >= `SEQ_INIT_BYTES;
   wire nextOk     = wholeBytes && byteCnt >= `SEQ_NEXT_BYTES;

   // Program state and internal address counter.
   seq_prog_pkg::prog_state_e state;
   seq_prog_pkg::prog_state_e next_state;
   logic [12:0] timer;
   logic [12:0] next_timer;
   logic [23:0] addrCnt;
   logic [23:0] next_addrCnt;
   logic        resetArmed;
   logic        next_resetArmed;
   logic        next_busy;
   logic        next_wel;
   logic        next_seq;
   logic        next_seqRaw;
   logic        next_ee;
   logic        next_pe;
   logic        next_progStart;
   logic [23:0] next_progAddr;
   logic [7:0]  next_progData;
   logic        next_accept;
   logic        next_reject;
   logic        next_devReset;

   wire [23:0] stepAddr = progAddr + 24'h1;
   wire        progDone = state == seq_prog_pkg::ST_PROG && timer == 13'h1;
   wire        startProt = blockProt(protectMap, capAddr);
   wire        stepProt  = blockProt(protectMap, stepAddr);
   wire        stepSusp  = eraseSuspended && stepAddr[23:`SEQ_BLOCK_LSB] == suspendBlock;

   // Next-state decision. Program completion is handled first, then the frame.
   always_comb
   begin
      next_state      = state;
      next_timer      = timer;
      next_addrCnt    = addrCnt;
      next_resetArmed = resetArmed;
      next_busy       = busyFlag;
      next_wel        = writeLatch;
      next_seqRaw     = seqProgramFlag;
      next_ee         = eraseErrorFlag;
      next_pe         = programErrorFlag;
      next_progStart  = 1'b0;
      next_progAddr   = progAddr;
      next_progData   = progData;
      next_accept     = 1'b0;
      next_reject     = 1'b0;
      next_devReset   = 1'b0;

      // Self-timed count; no host clocking needed.
      if (state == seq_prog_pkg::ST_PROG)
         next_timer = timer - 13'h1;

      if (progDone)
      begin
         next_state   = seq_prog_pkg::ST_IDLE;
         next_busy    = 1'b0;
         next_addrCnt = stepAddr;
         if (progAddr == LAST_ADDR || stepProt)
         begin
            next_seqRaw = 1'b0;
            next_wel    = 1'b0;
         end
         else if (stepSusp)
            next_seqRaw = 1'b0;
      end

      if (frameEnd && busyFlag)
      begin
         // Only the permitted subset passes while an operation runs.
         next_accept = wholeBytes && busyAllowed(capCmd);
         next_reject = !(wholeBytes && busyAllowed(capCmd));
      end
      else if (frameEnd && isSeqCmd)
      begin
         if (!writeLatch)
            next_reject = 1'b1;
         else if (!seqProgramFlag && !initOk || seqProgramFlag && !nextOk)
            next_wel = 1'b0;
         else if (!seqProgramFlag && startProt)
            next_wel = 1'b0;
         else
         begin
            next_accept    = 1'b1;
            next_seqRaw    = 1'b1;
            next_state     = seq_prog_pkg::ST_PROG;
            next_timer     = BP_LOAD;
            next_busy      = 1'b1;
            next_progStart = 1'b1;
            next_progAddr  = seqProgramFlag ? addrCnt : capAddr;
            next_progData  = capData;
            if (!seqProgramFlag)
            begin
               next_ee = 1'b0;
               next_pe = 1'b0;
            end
         end
      end
      else if (frameEnd)
      begin
         // In the mode only the allowed set passes; outside it all whole-byte frames pass on.
         next_accept = wholeBytes &&
                       (!seqProgramFlag || seqAllowed(capCmd));
         next_reject = !next_accept;
         if (next_accept && capCmd == `CMD_WREN)
            next_wel = 1'b1;
         if (next_accept && capCmd == `CMD_WRDI)
            next_wel = 1'b0;
         if (next_accept && capCmd == `CMD_TERM)
            next_seqRaw = 1'b0;
      end

      // Reset needs the enable as the directly preceding accepted command.
      if (frameEnd && next_accept)
      begin
         next_resetArmed = capCmd == `CMD_RST_EN;
         if (capCmd == `CMD_RST && resetArmed)
         begin
            next_devReset = 1'b1;
            next_state    = seq_prog_pkg::ST_IDLE;
            next_busy     = 1'b0;
            next_wel      = 1'b0;
            next_seqRaw   = 1'b0;
         end
      end

      // A failed byte sets both flags; set wins over any clear above.
      if (progDone && progFail)
      begin
         next_ee = 1'b1;
         next_pe = 1'b1;
      end
   end

   // Losing the write latch for any reason ends the mode.
   assign next_seq = next_seqRaw && next_wel;

   // State and flag registers.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state          <= seq_prog_pkg::ST_IDLE;
         timer          <= 13'h0;
         addrCnt        <= 24'h0;
         resetArmed     <= 1'b0;
         busyFlag       <= 1'b0;
         writeLatch     <= 1'b0;
         seqProgramFlag <= 1'b0;
         eraseErrorFlag <= 1'b0;
         programErrorFlag <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         timer          <= next_timer;
         addrCnt        <= next_addrCnt;
         resetArmed     <= next_resetArmed;
         busyFlag       <= next_busy;
         writeLatch     <= next_wel;
         seqProgramFlag <= next_seq;
         eraseErrorFlag <= next_ee;
         programErrorFlag <= next_pe;
      end
   end

   // Status register image, built from the next values so it moves with the flags.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         statusRegOne <= 8'h00;
      else
         statusRegOne <= {5'h00, next_seq, next_wel, next_busy};
   end

   // Array request and command report pulses.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         progStart   <= 1'b0;
         progAddr    <= 24'h0;
         progData    <= 8'h00;
         cmdAccept   <= 1'b0;
         cmdReject   <= 1'b0;
         cmdCode     <= 8'h00;
         deviceReset <= 1'b0;
      end
      else
      begin
         progStart   <= next_progStart;
         progAddr    <= next_progAddr;
         progData    <= next_progData;
         cmdAccept   <= next_accept;
         cmdReject   <= next_reject;
         cmdCode     <= frameEnd ? capCmd : cmdCode;
         deviceReset <= next_devReset;
      end
   end

endmodule

// >>> tb/sequential_byte_program_mode_props.sv
/* Checker for the sequential byte program block, bound to its ports.
   Assumes clk_sys samples everything and nrst is synchronous. */
`timescale 1ns/100ps
module sequential_byte_program_mode_props
#(
   parameter int          NUM_BLOCKS = 16,
   parameter logic [23:0] LAST_ADDR  = 24'h0FFFFF
)
(
   input logic                  clk_sys,
   input logic                  nrst,
   input logic [NUM_BLOCKS-1:0] protectMap,
   input logic                  progFail,
   input logic                  busyFlag,
   input logic                  writeLatch,
   input logic                  seqProgramFlag,
   input logic [7:0]            statusRegOne,
   input logic                  eraseErrorFlag,
   input logic                  programErrorFlag,
   input logic                  progStart,
   input logic [23:0]           progAddr,
   input logic                  cmdAccept,
   input logic                  cmdReject,
   input logic [7:0]            cmdCode,
   input logic                  deviceReset
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic [10:0] busyCnt;
   logic [23:0] lastAddr;
   wire  [23:0] nextAddr = progAddr + 24'h000001;
   wire         nextProt = (nextAddr[23:16] >= NUM_BLOCKS) || protectMap[nextAddr[23:16]];
   // Busy length and the last programmed address, for the timing and step checks.
   always_ff @(posedge clk_sys)
   begin
      busyCnt <= (busyFlag && nrst) ? busyCnt + 11'h001 : 11'h000;
      if (progStart)
         lastAddr <= progAddr;
   end
   // Command classes and end-of-range test, kept apart to keep the properties short.
   wire         cmdPulse = cmdAccept || cmdReject;
   wire         srMatch  = statusRegOne == {5'h00, seqProgramFlag, writeLatch, busyFlag};
   wire         busyCode = cmdCode inside {8'h05, 8'h35, 8'h15, 8'h65,
                                           8'h25, 8'hF0, 8'h66, 8'h99};
   wire         seqCode  = busyCode ||
                           cmdCode inside {8'hAD, 8'hAF, 8'h06, 8'h04, 8'h9F, 8'h90, 8'h94};
   wire         atEdge   = progAddr == LAST_ADDR ||
                           (progAddr[15:0] == 16'hFFFF && nextProt);
   // A reset pulse is registered with the busy drop, so it is seen in the same cycle.
   sequence progEnd;
      $fell(busyFlag) && !deviceReset;
   endsequence
   sequence modeLeft;
      ##[0:2] (!seqProgramFlag && !writeLatch);
   endsequence
   stat_map_a: assert property (srMatch)
      else $error("status register one does not mirror the flags");
   prog_busy_a: assert property (progStart |->
      busyFlag && seqProgramFlag && !$past(busyFlag))
      else $error("program start without busy and mode");
   busy_time_a: assert property (progEnd |-> busyCnt inside {[1599:1601]})
      else $error("byte program time is wrong");
   busy_gate_a: assert property (cmdAccept && $past(busyFlag) |-> busyCode)
      else $error("command accepted while busy");
   idle_gate_a: assert property (cmdPulse &&
      $past(seqProgramFlag) && !$past(busyFlag) |-> cmdAccept == seqCode)
      else $error("wrong gating in sequential mode");
   latch_exit_a: assert property ($fell(writeLatch) |-> !seqProgramFlag)
      else $error("mode kept after latch cleared");
   addr_step_a: assert property (progStart && $past(seqProgramFlag) |->
      progAddr == lastAddr + 24'h000001)
      else $error("address counter did not step by one");
   end_exit_a: assert property (progEnd and atEdge |-> modeLeft)
      else $error("mode kept past the end of the usable range");
   err_pair_a: assert property (programErrorFlag == eraseErrorFlag)
      else $error("error flags disagree");
   err_cause_a: assert property ($rose(programErrorFlag) |-> $past(progFail))
      else $error("error flag set without a failed byte");
endmodule
bind sequential_byte_program_mode sequential_byte_program_mode_props
#(
   .NUM_BLOCKS (NUM_BLOCKS),
   .LAST_ADDR  (LAST_ADDR)
)
u_props
(
   .clk_sys          (clk_sys),
   .nrst             (nrst),
   .protectMap       (protectMap),
   .progFail         (progFail),
   .busyFlag         (busyFlag),
   .writeLatch       (writeLatch),
   .seqProgramFlag   (seqProgramFlag),
   .statusRegOne     (statusRegOne),
   .eraseErrorFlag   (eraseErrorFlag),
   .programErrorFlag (programErrorFlag),
   .progStart        (progStart),
   .progAddr         (progAddr),
   .cmdAccept        (cmdAccept),
   .cmdReject        (cmdReject),
   .cmdCode          (cmdCode),
   .deviceReset      (deviceReset)
);

// >>> tb/sequential_byte_program_mode_tb.sv
/* Bench for the sequential byte program block, framed by the host model.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/100ps
module sequential_byte_program_mode_tb;
   logic        clk_sys, nrst, sck, csN, mosi, eraseSuspended, progFail;
   logic [15:0] protectMap;
   logic [7:0]  suspendBlock, statusRegOne, progData, cmdCode;
   logic [23:0] progAddr;
   logic        busyFlag, writeLatch, seqProgramFlag, eraseErrorFlag, programErrorFlag;
   logic        progStart, cmdAccept, cmdReject, deviceReset, sawAcc, sawRej, sawProg, sawRst;
   int          errors, total_checks;
   int          cycles = 0;
   logic [7:0]  codes [53] = '{8'h06, 8'h25, 8'h05, 8'h35, 8'h15, 8'h65, 8'h9F, 8'h90, 8'h94,
      8'h03, 8'h3B, 8'h6B, 8'hEB, 8'hE7, 8'h0B, 8'hD4, 8'h84, 8'h81, 8'hDB, 8'h20, 8'h52,
      8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2, 8'h32, 8'h88, 8'h0A, 8'hB0, 8'h75, 8'hD0, 8'h7A,
      8'h50, 8'h36, 8'h39, 8'h7E, 8'h98, 8'h3C, 8'h3D, 8'h9B, 8'h4B, 8'h01, 8'h31, 8'h11,
      8'h71, 8'h6F, 8'hB9, 8'hAB, 8'h79, 8'h5A, 8'h77, 8'hEF};
   spi_host u_host (.csN(csN), .sck(sck), .mosi(mosi));
   sequential_byte_program_mode u_dut
   (
      .clk_sys          (clk_sys),
      .nrst             (nrst),
      .sck              (sck),
      .csN              (csN),
      .mosi             (mosi),
      .protectMap       (protectMap),
      .eraseSuspended   (eraseSuspended),
      .suspendBlock     (suspendBlock),
      .progFail         (progFail),
      .busyFlag         (busyFlag),
      .writeLatch       (writeLatch),
      .seqProgramFlag   (seqProgramFlag),
      .statusRegOne     (statusRegOne),
      .eraseErrorFlag   (eraseErrorFlag),
      .programErrorFlag (programErrorFlag),
      .progStart        (progStart),
      .progAddr         (progAddr),
      .progData         (progData),
      .cmdAccept        (cmdAccept),
      .cmdReject        (cmdReject),
      .cmdCode          (cmdCode),
      .deviceReset      (deviceReset)
   );
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Pulses are held until the next frame; a stuck run is cut short.
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cmdAccept === 1'b1)
         sawAcc <= 1'b1;
      if (cmdReject === 1'b1)
         sawRej <= 1'b1;
      if (progStart === 1'b1)
         sawProg <= 1'b1;
      if (deviceReset === 1'b1)
         sawRst <= 1'b1;
      if (cycles == 60000)
      begin
         errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // One frame, then enough cycles for the synced answer to land.
   task automatic send(input int n, input logic [47:0] d);
      sawAcc = 1'b0;
      sawRej = 1'b0;
      sawProg = 1'b0;
      sawRst = 1'b0;
      u_host.frame(n, d);
      repeat (10) @(posedge clk_sys);
      #1;
   endtask
   // Polling status is faster than sitting out the whole program time.
   task automatic waitIdle();
      for (int i = 0; i < 40 && busyFlag !== 1'b0; i++)
         send(8, {8'h05, 40'h0});
   endtask
   task automatic enter(input logic [23:0] a);
      send(8, {8'h06, 40'h0});
      send(40, {8'hAD, a, 16'h3C00});
      waitIdle();
   endtask
   initial
   begin
      nrst = 1'b0;
      protectMap = 16'h0000;
      eraseSuspended = 1'b0;
      suspendBlock = 8'h00;
      progFail = 1'b0;
      errors = 0;
      total_checks = 0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      // Entry with two data bytes: only the last one is programmed.
      send(8, {8'h06, 40'h0});
      send(48, {8'hAD, 24'h0FFFFE, 16'h115A});
      chk(sawProg, 1'b1);
      chk(progAddr, 24'h0FFFFE);
      chk(progData, 8'h5A);
      chk(statusRegOne, 8'h07);
      send(8, {8'h03, 40'h0});
      chk(sawRej, 1'b1);
      waitIdle();
      // Idle in the mode: the first nine codes pass, the rest are refused.
      foreach (codes[i])
      begin
         send(8, {codes[i], 40'h0});
         chk(sawAcc, i < 9);
         chk(sawRej, i >= 9);
         chk(cmdCode, codes[i]);
      end
      // The next byte goes to the counter; the top of the array ends the mode.
      send(16, {8'hAF, 8'hC3, 32'h0});
      chk(progAddr, 24'h0FFFFF);
      chk(progData, 8'hC3);
      waitIdle();
      chk(statusRegOne, 8'h00);
      // A release inside a byte programs nothing.
      send(8, {8'h06, 40'h0});
      send(44, {8'hAD, 24'h000100, 16'h7700});
      chk(sawProg, 1'b0);
      chk(writeLatch, 1'b0);
      @(posedge clk_sys);
      protectMap <= 16'h0004;
      progFail <= 1'b1;
      send(8, {8'h06, 40'h0});
      send(40, {8'hAD, 24'h020000, 16'h3C00});
      chk(sawProg, 1'b0);
      chk(writeLatch, 1'b0);
      // Programming up to the protected block ends the mode; the fail shows.
      enter(24'h01FFFF);
      chk(statusRegOne, 8'h00);
      chk({programErrorFlag, eraseErrorFlag}, 2'h3);
      @(posedge clk_sys);
      progFail <= 1'b0;
      eraseSuspended <= 1'b1;
      suspendBlock <= 8'h04;
      enter(24'h03FFFF);
      chk(statusRegOne, 8'h02);
      chk({programErrorFlag, eraseErrorFlag}, 2'h0);
      // Terminate keeps the latch; write disable and reset clear it.
      enter(24'h000010);
      send(8, {8'hF0, 40'h0});
      chk(statusRegOne, 8'h02);
      enter(24'h000020);
      send(8, {8'h04, 40'h0});
      chk(statusRegOne, 8'h00);
      enter(24'h000030);
      send(8, {8'h66, 40'h0});
      send(8, {8'h99, 40'h0});
      chk(statusRegOne, 8'h00);
      chk(sawRst, 1'b1);
      wrap_up();
   end
endmodule

// >>> tb/spi_host.sv
/* Host model for the serial side: drives csN, sck and mosi in mode 0.
   Assumes the bench calls frame() one frame at a time. */
`timescale 1ns/100ps
module spi_host
(
   output logic csN,
   output logic sck,
   output logic mosi
);
   // The serial clock stands still low outside frames.
   // Chip select rises just after time zero, so the device's frame flop is
   // cleared by a real edge instead of racing the start of simulation.
   initial
   begin
      sck = 1'b0;
      mosi = 1'b0;
      #1 csN = 1'b1;
   end
   // Sends the top n bits of d, MSB first, at a 48 ns serial clock period.
   task automatic frame(input int n, input logic [47:0] d);
      csN = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         mosi = d[47 - i];
         #24 sck = 1'b1;
         #24 sck = 1'b0;
      end
      #24 csN = 1'b1;
      // A released data line must not keep its last value.
      mosi = ~mosi;
      #100;
   endtask
endmodule
